// >>> include/rsi_pkg.sv
// Package: register map, field positions and status types for the radio
// status and interrupt register block.
// Assumes an AHB-Lite slave with 32-bit data, one register per word.
package rsi_pkg;

  // ----------------------------------------
  // Register map (printed offsets are indices)
  // ----------------------------------------
  localparam logic [7:0] RSI_IDX_REVISION = 8'h01;
  localparam logic [7:0] RSI_IDX_CONDITION = 8'h02;
  localparam logic [7:0] RSI_IDX_EVENTS = 8'h03;
  localparam logic [7:0] RSI_IDX_ENABLE = 8'h05;
  localparam logic [7:0] RSI_IDX_SYS_STATUS = 8'h08;
  localparam logic [7:0] RSI_IDX_SYS_MASK = 8'h09;
  localparam int RSI_WORD_SHIFT = 2;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RSI_REV_W = 5;
  localparam int RSI_FLG_FIFO_ERR = 7;
  localparam int RSI_FLG_TX_AFULL = 6;
  localparam int RSI_FLG_TX_AEMPTY = 5;
  localparam int RSI_FLG_RX_AFULL = 4;
  localparam int RSI_FLG_EXT = 3;
  localparam int RSI_FLG_PKT_SENT = 2;
  localparam int RSI_FLG_PKT_VALID = 1;
  localparam int RSI_FLG_CRC_ERR = 0;
  localparam int RSI_FLG_W = 8;
  localparam int RSI_CNT_W = 7;
  localparam int RSI_THR_W = 6;

  // System-side sticky events (bit 0: host line asserted, bit 1: events register read by host)
  localparam int RSI_SYS_ASSERT = 0;
  localparam int RSI_SYS_ACK = 1;
  localparam int RSI_SYS_W = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RSI_ENABLE_RST = 8'h00;
  localparam logic [7:0] RSI_FLAGS_RST = 8'h00;
  localparam logic [1:0] RSI_SYS_RST = 2'h0;

  // Chip power state encodings
  typedef enum logic [1:0] {
    RSI_PWR_IDLE = 2'h0,
    RSI_PWR_RX = 2'h1,
    RSI_PWR_TX = 2'h2
  } rsi_pwr_t;

  // Radio core status carried into the block
  typedef struct packed {
    logic fifo_ovfl;
    logic fifo_unfl;
    logic rx_empty;
    logic hdr_err;
    rsi_pwr_t pwr;
  } rsi_cond_t;

  // Radio core events carried into the block
  typedef struct packed {
    logic fifo_reset;
    logic tx_start;
    logic fifo_mode;
    logic pkt_sent;
    logic pkt_rx_ok;
    logic sync_ok;
    logic rx_start;
    logic crc_bad;
    logic gpio_event;
    logic [RSI_CNT_W-1:0] tx_count;
    logic [RSI_CNT_W-1:0] rx_count;
    logic [RSI_THR_W-1:0] tx_afull_thr;
    logic [RSI_THR_W-1:0] tx_aempty_thr;
    logic [RSI_THR_W-1:0] rx_afull_thr;
  } rsi_evt_t;

endpackage : rsi_pkg

// >>> src/rsi_flags.sv
// Module: the eight interrupt/status flags with their set and clear logic.
// Assumes event inputs come from radio logic on the same clock.
`timescale 1ns/1ns
module rsi_flags
  import rsi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire rsi_evt_t evt,
  input wire logic [RSI_FLG_W-1:0] enable,
  input wire logic read_ack,
  input wire logic fifo_fault,
  output logic [RSI_FLG_W-1:0] flags,
  output logic rise
);

  logic [RSI_FLG_W-1:0] flags_r;
  logic [RSI_FLG_W-1:0] set_w;
  logic [RSI_FLG_W-1:0] clr_w;
  logic [RSI_FLG_W-1:0] flags_nxt;

  // ----------------------------------------
  // Set and clear terms
  // ----------------------------------------
  assign set_w[RSI_FLG_FIFO_ERR] = fifo_fault;
  assign clr_w[RSI_FLG_FIFO_ERR] = evt.fifo_reset;
  assign set_w[RSI_FLG_TX_AFULL] = {1'b0, evt.tx_afull_thr} < evt.tx_count;
  assign clr_w[RSI_FLG_TX_AFULL] = ~set_w[RSI_FLG_TX_AFULL];
  assign set_w[RSI_FLG_TX_AEMPTY] = evt.tx_count <= {1'b0, evt.tx_aempty_thr};
  assign clr_w[RSI_FLG_TX_AEMPTY] = ~set_w[RSI_FLG_TX_AEMPTY];
  assign set_w[RSI_FLG_RX_AFULL] = {1'b0, evt.rx_afull_thr} < evt.rx_count;
  assign clr_w[RSI_FLG_RX_AFULL] = evt.rx_count < {1'b0, evt.rx_afull_thr};
  assign set_w[RSI_FLG_EXT] = evt.gpio_event;
  assign clr_w[RSI_FLG_EXT] = 1'b0;
  assign set_w[RSI_FLG_PKT_SENT] = evt.pkt_sent;
  assign clr_w[RSI_FLG_PKT_SENT] = ~evt.fifo_mode | evt.tx_start;
  assign set_w[RSI_FLG_PKT_VALID] = evt.pkt_rx_ok;
  assign clr_w[RSI_FLG_PKT_VALID] = evt.sync_ok;
  assign set_w[RSI_FLG_CRC_ERR] = evt.crc_bad;
  assign clr_w[RSI_FLG_CRC_ERR] = evt.rx_start;

  // Set wins over any clear; enabled flags also clear on host read
  assign flags_nxt = set_w | (flags_r & ~clr_w & ~(read_ack ? enable : '0));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_r <= RSI_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;
  assign rise = |(flags_nxt & ~flags_r & enable);

endmodule : rsi_flags

// >>> src/rsi_regs.sv
// Module: AHB-Lite register block for revision, device condition and
// first event flags with interrupt line to the host.
// Assumes radio status and events arrive synchronous to clk_sys.
//
// Overview of operation
// - Read-only five-bit revision, upper bits zero
// - Status bit 7 shows FIFO overflow
// - Status bit 6 shows FIFO underflow
// - Status bit 5 high while receive FIFO empty
// - Status bit 4 shows header check failure
// - Status bits 1:0 give power state
// - FIFO error latches until FIFO reset
// - TX almost-full tracks count above threshold
// - TX almost-empty tracks count at/below threshold
// - RX almost-full sets above, clears below threshold
// - External flag sets on GPIO event
// - Packet-sent sets on send, clears on restart or while FIFO mode is off
// - Valid-packet sets on receive, clears on sync
// - CRC-error sets on mismatch, clears on reception
// - Enabled flag rising drives interrupt low
// - Host read releases line, clears enabled flags
// - Disabled flags are plain status, never read-cleared
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module rsi_regs
  import rsi_pkg::*;
#(
  parameter logic [RSI_REV_W-1:0] REVISION = 5'h15 // Arbitrary value
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire rsi_cond_t cond,
  input wire rsi_evt_t evt,
  output logic host_interrupt_n,
  output logic sys_irq
);

  initial begin
    if (RSI_FLG_W != 8) begin
      $error("Flag width must be eight");
    end
  end

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  logic dp_valid_r;
  logic dp_write_r;
  logic [7:0] dp_idx_r;
  logic [RSI_FLG_W-1:0] enable_r;
  logic [RSI_SYS_W-1:0] sys_status_r;
  logic [RSI_SYS_W-1:0] sys_mask_r;
  logic host_interrupt_n_r;
  logic [31:0] hrdata_r;
  logic sys_irq_r;
  logic [RSI_FLG_W-1:0] flags;
  logic rise;

  wire addr_take = hsel & hready & htrans[1];
  wire [7:0] addr_idx = haddr[RSI_WORD_SHIFT +: 8];
  wire rd_events = addr_take & ~hwrite & (addr_idx == RSI_IDX_EVENTS);
  wire wr_go = dp_valid_r & dp_write_r;

  // Condition register, reserved bits read zero
  wire [7:0] cond_byte = {cond.fifo_ovfl, cond.fifo_unfl, cond.rx_empty,
    cond.hdr_err, 2'b00, cond.pwr};
  wire fifo_fault = cond.fifo_ovfl | cond.fifo_unfl;

  function automatic logic [31:0] read_mux(input logic [7:0] idx);
    if (idx == RSI_IDX_REVISION) begin
      read_mux = {27'h0, REVISION};
    end else if (idx == RSI_IDX_CONDITION) begin
      read_mux = {24'h0, cond_byte};
    end else if (idx == RSI_IDX_EVENTS) begin
      read_mux = {24'h0, flags};
    end else if (idx == RSI_IDX_ENABLE) begin
      read_mux = {24'h0, enable_r};
    end else if (idx == RSI_IDX_SYS_STATUS) begin
      read_mux = {30'h0, sys_status_r};
    end else if (idx == RSI_IDX_SYS_MASK) begin
      read_mux = {30'h0, sys_mask_r};
    end else begin
      read_mux = 32'h0;
    end
  endfunction : read_mux

  rsi_flags u_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .evt(evt),
    .enable(enable_r),
    .read_ack(rd_events),
    .fifo_fault(fifo_fault),
    .flags(flags),
    .rise(rise)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_idx_r <= 8'h00;
    end else if (hready) begin
      dp_valid_r <= addr_take;
      dp_write_r <= hwrite;
      dp_idx_r <= addr_idx;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata_r <= 32'h0;
    end else if (addr_take & ~hwrite) begin
      hrdata_r <= read_mux(addr_idx);
    end
  end

  // ----------------------------------------
  // Enable mask and host line
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enable_r <= RSI_ENABLE_RST;
    end else if (wr_go & (dp_idx_r == RSI_IDX_ENABLE)) begin
      enable_r <= hwdata[RSI_FLG_W-1:0];
    end
  end

  // Rise takes priority over a same-cycle read release
  wire irq_assert = rise;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      host_interrupt_n_r <= 1'b1;
    end else if (irq_assert) begin
      host_interrupt_n_r <= 1'b0;
    end else if (rd_events) begin
      host_interrupt_n_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // System interrupt (write one to clear)
  // ----------------------------------------
  wire [RSI_SYS_W-1:0] sys_set = {rd_events, irq_assert};
  wire [RSI_SYS_W-1:0] sys_clr = (wr_go & (dp_idx_r == RSI_IDX_SYS_STATUS)) ?
    hwdata[RSI_SYS_W-1:0] : '0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sys_status_r <= RSI_SYS_RST;
      sys_mask_r <= RSI_SYS_RST;
      sys_irq_r <= 1'b0;
    end else begin
      sys_status_r <= sys_set | (sys_status_r & ~sys_clr);
      if (wr_go & (dp_idx_r == RSI_IDX_SYS_MASK)) begin
        sys_mask_r <= hwdata[RSI_SYS_W-1:0];
      end
      sys_irq_r <= |((sys_set | (sys_status_r & ~sys_clr)) & sys_mask_r);
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign host_interrupt_n = host_interrupt_n_r;
  assign sys_irq = sys_irq_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_read_evt;
    rd_events ##1 1'b1;
  endsequence

  property p_rev_read;
    @(posedge clk_sys) disable iff (rst)
      (addr_take & ~hwrite & (addr_idx == RSI_IDX_REVISION)) |=> (hrdata[31:5] == 27'h0);
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("Revision upper bits not zero");

  property p_irq_low;
    @(posedge clk_sys) disable iff (rst) rise |=> !host_interrupt_n;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("Line not low after rise");

  property p_read_release;
    @(posedge clk_sys) disable iff (rst) (rd_events & !rise) |=> host_interrupt_n;
  endproperty
  a_read_release: assert property (p_read_release) else $error("Line not released");

  property p_read_clear;
    @(posedge clk_sys) disable iff (rst)
      (rd_events & !evt.pkt_rx_ok & enable_r[RSI_FLG_PKT_VALID]) |=> !flags[RSI_FLG_PKT_VALID];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Enabled flag kept");

  property p_disabled_kept;
    @(posedge clk_sys) disable iff (rst)
      (s_read_evt and (flags[RSI_FLG_EXT] & !enable_r[RSI_FLG_EXT])) |-> flags[RSI_FLG_EXT];
  endproperty
  a_disabled_kept: assert property (p_disabled_kept) else $error("Disabled flag cleared");

  property p_fifo_err_hold;
    @(posedge clk_sys) disable iff (rst)
      (flags[RSI_FLG_FIFO_ERR] & !evt.fifo_reset & !(rd_events & enable_r[RSI_FLG_FIFO_ERR]))
        |=> flags[RSI_FLG_FIFO_ERR];
  endproperty
  a_fifo_err_hold: assert property (p_fifo_err_hold) else $error("FIFO error dropped");

  property p_ext_set;
    @(posedge clk_sys) disable iff (rst) evt.gpio_event |=> flags[RSI_FLG_EXT];
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("External flag not set");

  property p_crc;
    @(posedge clk_sys) disable iff (rst)
      (evt.rx_start & !evt.crc_bad) |=> !flags[RSI_FLG_CRC_ERR];
  endproperty
  a_crc: assert property (p_crc) else $error("CRC flag not cleared");

  property p_sent;
    @(posedge clk_sys) disable iff (rst) evt.pkt_sent |=> flags[RSI_FLG_PKT_SENT];
  endproperty
  a_sent: assert property (p_sent) else $error("Sent flag not set");

  property p_cond;
    @(posedge clk_sys) disable iff (rst)
      (addr_take & ~hwrite & (addr_idx == RSI_IDX_CONDITION))
        |=> (hrdata[7:0] == {$past(cond.fifo_ovfl), $past(cond.fifo_unfl),
        $past(cond.rx_empty), $past(cond.hdr_err), 2'b00, $past(cond.pwr)});
  endproperty
  a_cond: assert property (p_cond) else $error("Condition read wrong");

  property p_cond_rsv;
    @(posedge clk_sys) disable iff (rst)
      (addr_take & ~hwrite & (addr_idx == RSI_IDX_CONDITION)) |=> (hrdata[31:8] == 24'h0);
  endproperty
  a_cond_rsv: assert property (p_cond_rsv) else $error("Condition upper bits set");

  property p_rev_value;
    @(posedge clk_sys) disable iff (rst)
      (addr_take & ~hwrite & (addr_idx == RSI_IDX_REVISION))
        |=> (hrdata[RSI_REV_W-1:0] == REVISION);
  endproperty
  a_rev_value: assert property (p_rev_value) else $error("Revision value wrong");

  property p_fifo_err_set;
    @(posedge clk_sys) disable iff (rst)
      fifo_fault |=> flags[RSI_FLG_FIFO_ERR];
  endproperty
  a_fifo_err_set: assert property (p_fifo_err_set) else $error("FIFO error not set");

  property p_fifo_err_clr;
    @(posedge clk_sys) disable iff (rst)
      (evt.fifo_reset & !fifo_fault) |=> !flags[RSI_FLG_FIFO_ERR];
  endproperty
  a_fifo_err_clr: assert property (p_fifo_err_clr) else $error("FIFO error kept");

  property p_txaf_set;
    @(posedge clk_sys) disable iff (rst)
      ({1'b0, evt.tx_afull_thr} < evt.tx_count) |=> flags[RSI_FLG_TX_AFULL];
  endproperty
  a_txaf_set: assert property (p_txaf_set) else $error("TX almost full not set");

  property p_txaf_clr;
    @(posedge clk_sys) disable iff (rst)
      (evt.tx_count <= {1'b0, evt.tx_afull_thr}) |=> !flags[RSI_FLG_TX_AFULL];
  endproperty
  a_txaf_clr: assert property (p_txaf_clr) else $error("TX almost full kept");

  property p_txae_set;
    @(posedge clk_sys) disable iff (rst)
      (evt.tx_count <= {1'b0, evt.tx_aempty_thr}) |=> flags[RSI_FLG_TX_AEMPTY];
  endproperty
  a_txae_set: assert property (p_txae_set) else $error("TX almost empty not set");

  property p_txae_clr;
    @(posedge clk_sys) disable iff (rst)
      ({1'b0, evt.tx_aempty_thr} < evt.tx_count) |=> !flags[RSI_FLG_TX_AEMPTY];
  endproperty
  a_txae_clr: assert property (p_txae_clr) else $error("TX almost empty kept");

  property p_rxaf_set;
    @(posedge clk_sys) disable iff (rst)
      ({1'b0, evt.rx_afull_thr} < evt.rx_count) |=> flags[RSI_FLG_RX_AFULL];
  endproperty
  a_rxaf_set: assert property (p_rxaf_set) else $error("RX almost full not set");

  property p_rxaf_clr;
    @(posedge clk_sys) disable iff (rst)
      (evt.rx_count < {1'b0, evt.rx_afull_thr}) |=> !flags[RSI_FLG_RX_AFULL];
  endproperty
  a_rxaf_clr: assert property (p_rxaf_clr) else $error("RX almost full kept");

  property p_sent_clr;
    @(posedge clk_sys) disable iff (rst)
      ((!evt.fifo_mode | evt.tx_start) & !evt.pkt_sent) |=> !flags[RSI_FLG_PKT_SENT];
  endproperty
  a_sent_clr: assert property (p_sent_clr) else $error("Sent flag kept");

  property p_valid_set;
    @(posedge clk_sys) disable iff (rst)
      evt.pkt_rx_ok |=> flags[RSI_FLG_PKT_VALID];
  endproperty
  a_valid_set: assert property (p_valid_set) else $error("Valid flag not set");

  property p_valid_clr;
    @(posedge clk_sys) disable iff (rst)
      (evt.sync_ok & !evt.pkt_rx_ok) |=> !flags[RSI_FLG_PKT_VALID];
  endproperty
  a_valid_clr: assert property (p_valid_clr) else $error("Valid flag kept");

  property p_crc_set;
    @(posedge clk_sys) disable iff (rst)
      evt.crc_bad |=> flags[RSI_FLG_CRC_ERR];
  endproperty
  a_crc_set: assert property (p_crc_set) else $error("CRC flag not set");

  property p_irq_hold;
    @(posedge clk_sys) disable iff (rst)
      (!host_interrupt_n & !rd_events) |=> !host_interrupt_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("Line released without read");

  property p_ext_clr_rd;
    @(posedge clk_sys) disable iff (rst)
      (rd_events & enable_r[RSI_FLG_EXT] & !evt.gpio_event) |=> !flags[RSI_FLG_EXT];
  endproperty
  a_ext_clr_rd: assert property (p_ext_clr_rd) else $error("Enabled external kept");

  property p_enable_wr;
    @(posedge clk_sys) disable iff (rst)
      (wr_go & (dp_idx_r == RSI_IDX_ENABLE)) |=> (enable_r == $past(hwdata[RSI_FLG_W-1:0]));
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("Enable mask not written");

  property p_no_irq_disabled;
    @(posedge clk_sys) disable iff (rst)
      (host_interrupt_n & (enable_r == '0)) |=> host_interrupt_n;
  endproperty
  a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("Masked line low");

endmodule : rsi_regs

// >>> testbench/rsi_host_model.sv
// Host model: an AHB-Lite master that performs single word transfers.
// Assumes the slave hreadyout is looped back as hready.
`timescale 1ns/1ns
module rsi_host_model (
  input wire logic clk_sys,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ----------------------------------------
  // Bus idle at time zero
  // ----------------------------------------
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  task automatic wait_ready(output logic ok);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hready !== 1'b1 && n < 16) begin
      @(posedge clk_sys);
      n++;
    end
    ok = (hready === 1'b1);
  endtask : wait_ready

  // ----------------------------------------
  // One transfer, entered just after a rising edge
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    logic ok_a;
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready(ok_a);
    hsel <= 1'b0;
    htrans <= 2'h0;
    // No meaningful write data during a read
    hwdata <= w ? wd : ~hwdata;
    wait_ready(ok);
    rd = hrdata;
    ok = ok & ok_a;
  endtask : xfer
endmodule : rsi_host_model

// >>> testbench/test_radio_status_interrupt_regs.sv
// Testbench: register reads, event flags and interrupt lines of rsi_regs.
// Assumes the host model drives the bus and the bench drives radio inputs.
`timescale 1ns/1ns
module test_radio_status_interrupt_regs
  import rsi_pkg::*;
;
  typedef struct packed {
    logic [7:0] en;
    logic [8:0] pl;
    logic [6:0] txc;
    logic [6:0] rxc;
    logic [7:0] exp1;
    logic irq_n;
    logic [7:0] exp2;
  } rsi_row_t;
  localparam int N_ROWS = 18;
  localparam rsi_row_t ROWS [N_ROWS] = '{
    '{8'hff, 9'h041, 7'h10, 7'h00, 8'h08, 1'b0, 8'h00},
    '{8'hff, 9'h060, 7'h10, 7'h00, 8'h04, 1'b0, 8'h00},
    '{8'hff, 9'h050, 7'h10, 7'h00, 8'h02, 1'b0, 8'h00},
    '{8'hff, 9'h042, 7'h10, 7'h00, 8'h01, 1'b0, 8'h00},
    '{8'h00, 9'h040, 7'h30, 7'h00, 8'h00, 1'b1, 8'h00},
    '{8'h00, 9'h040, 7'h31, 7'h00, 8'h40, 1'b1, 8'h40},
    '{8'h00, 9'h0c0, 7'h30, 7'h00, 8'h00, 1'b1, 8'h00},
    '{8'h00, 9'h040, 7'h04, 7'h00, 8'h20, 1'b1, 8'h20},
    '{8'h00, 9'h040, 7'h05, 7'h00, 8'h00, 1'b1, 8'h00},
    '{8'h00, 9'h040, 7'h05, 7'h30, 8'h00, 1'b1, 8'h00},
    '{8'h00, 9'h040, 7'h05, 7'h31, 8'h10, 1'b1, 8'h10},
    '{8'h00, 9'h040, 7'h05, 7'h2f, 8'h00, 1'b1, 8'h00},
    '{8'h08, 9'h043, 7'h05, 7'h2f, 8'h09, 1'b0, 8'h01},
    '{8'h00, 9'h070, 7'h05, 7'h2f, 8'h07, 1'b1, 8'h07},
    '{8'h00, 9'h04c, 7'h05, 7'h2f, 8'h04, 1'b1, 8'h04},
    '{8'h00, 9'h000, 7'h05, 7'h2f, 8'h00, 1'b1, 8'h00},
    '{8'h00, 9'h060, 7'h05, 7'h2f, 8'h04, 1'b1, 8'h04},
    '{8'h00, 9'h0c0, 7'h05, 7'h2f, 8'h00, 1'b1, 8'h00}
  };
  localparam logic [5:0] CONDS [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h00, 6'h01, 6'h02};
  logic clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp, host_interrupt_n, sys_irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic ok;
  rsi_cond_t cond;
  rsi_evt_t evt;
  int n_errors, comparisons;
  assign hready = hreadyout;

  rsi_host_model host (.clk_sys(clk_sys), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // Revision value is arbitrary
  rsi_regs #(.REVISION(5'h0a)) dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cond(cond), .evt(evt), .host_interrupt_n(host_interrupt_n), .sys_irq(sys_irq));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("Error %0t: got %h, want %h", $time, seen, want);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    host.xfer(w, idx, wd, rd, ok);
    if (!ok) begin
      n_errors++;
      end_sim();
    end
  endtask : bus

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] want);
    bus(1'b0, idx, 32'h0);
    check(rd, want);
    check(hresp, 1'b0);
  endtask : rd_chk

  // Event pulses last one cycle; FIFO mode level and counts persist
  task automatic pulse(input logic [8:0] pl, input logic [6:0] txc, input logic [6:0] rxc);
    evt <= {pl, txc, rxc, 6'h30, 6'h04, 6'h30};
    @(posedge clk_sys);
    evt <= {pl & 9'h040, txc, rxc, 6'h30, 6'h04, 6'h30};
    tick(2);
  endtask : pulse

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    cond = '0;
    evt = {9'h040, 7'h10, 7'h00, 6'h30, 6'h04, 6'h30};
    n_errors = 0;
    comparisons = 0;
    tick(3);
    rst <= 1'b0;
    check(host_interrupt_n, 1'b1);
    rd_chk(RSI_IDX_EVENTS, 32'h0);
    bus(1'b1, RSI_IDX_REVISION, 32'hffff_ffff);
    rd_chk(RSI_IDX_REVISION, 32'h0000_000a);
    for (int i = 0; i < 7; i++) begin
      cond <= rsi_cond_t'(CONDS[i]);
      tick(1);
      rd_chk(RSI_IDX_CONDITION, {24'h0, CONDS[i][5:2], 2'b00, CONDS[i][1:0]});
    end
    rd_chk(RSI_IDX_EVENTS, 32'h80);
    rd_chk(RSI_IDX_EVENTS, 32'h80);
    pulse(9'h140, 7'h10, 7'h00);
    rd_chk(RSI_IDX_EVENTS, 32'h0);
    for (int i = 0; i < N_ROWS; i++) begin
      bus(1'b1, RSI_IDX_ENABLE, {24'h0, ROWS[i].en});
      pulse(ROWS[i].pl, ROWS[i].txc, ROWS[i].rxc);
      check(host_interrupt_n, ROWS[i].irq_n);
      rd_chk(RSI_IDX_EVENTS, {24'h0, ROWS[i].exp1});
      check(host_interrupt_n, 1'b1);
      rd_chk(RSI_IDX_EVENTS, {24'h0, ROWS[i].exp2});
    end
    rd_chk(RSI_IDX_SYS_STATUS, 32'h3);
    check(sys_irq, 1'b0);
    bus(1'b1, RSI_IDX_SYS_MASK, 32'h3);
    tick(2);
    check(sys_irq, 1'b1);
    rd_chk(RSI_IDX_SYS_MASK, 32'h3);
    bus(1'b1, RSI_IDX_SYS_STATUS, 32'h3);
    tick(1);
    check(sys_irq, 1'b0);
    rd_chk(RSI_IDX_SYS_STATUS, 32'h0);
    bus(1'b1, 8'h3f, 32'hffff_ffff);
    rd_chk(8'h3f, 32'h0);
    bus(1'b1, RSI_IDX_ENABLE, 32'h08);
    pulse(9'h041, 7'h05, 7'h2f);
    check(host_interrupt_n, 1'b0);
    check(sys_irq, 1'b1);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    check(host_interrupt_n, 1'b1);
    check(sys_irq, 1'b0);
    rd_chk(RSI_IDX_SYS_MASK, 32'h0);
    rd_chk(RSI_IDX_ENABLE, 32'h0);
    rd_chk(RSI_IDX_SYS_STATUS, 32'h0);
    rd_chk(RSI_IDX_EVENTS, 32'h0);
    end_sim();
  end
endmodule : test_radio_status_interrupt_regs
